// ===== common/rsc_defines.svh
// constants for the reset source controller
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// register indices, byte address is index times four
`define RSC_CTRL_IDX 10'h086
`define RSC_ISTAT_IDX 10'h088
`define RSC_ICLR_IDX 10'h089
`define RSC_IEN_IDX 10'h08A
`define RSC_CFG_IDX 10'h08B

// control register fields
`define RSC_POWER_ON_CAUSE_FLAG_BIT 7
`define RSC_PIN_RESET_CAUSE_FLAG_BIT 6
`define RSC_WATCHDOG_CAUSE_FLAG_BIT 5
`define RSC_DEBUG_CAUSE_FLAG_BIT 4
`define RSC_BROWNOUT_CAUSE_FLAG_BIT 3
`define RSC_BROWNOUT_LEVEL_SELECT_MSB 2
`define RSC_BROWNOUT_LEVEL_SELECT_LSB 1
`define RSC_BROWNOUT_ENABLE_BIT 0
`define RSC_CTRL_RST 8'h81
`define RSC_CTRL_LOW_RST 3'h1

// interrupt status bits
`define RSC_IRQ_BOOT_BIT 0
`define RSC_IRQ_BODOFF_BIT 1
`define RSC_IRQ_WDOFF_BIT 2
`define RSC_IRQ_W 3

// configuration option
`define RSC_CFG_PINRST_BIT 0
`define RSC_CFG_RST 8'h01
`define RSC_RESET_VECTOR 16'h0000

// timing
`define RSC_CLK_KHZ 10000
`define RSC_GLITCH_NS 7000
`define RSC_GLITCH_CYC ((`RSC_GLITCH_NS * `RSC_CLK_KHZ + 999999) / 1000000)
`define RSC_STAB_US 16000
`define RSC_STAB_CYC (`RSC_STAB_US * `RSC_CLK_KHZ / 1000)
`define RSC_OSC_KHZ 125
`define RSC_OSC_DIV 32
`define RSC_CFG_PERIODS 8'h30
`define RSC_CFG_CYC (`RSC_CFG_PERIODS * `RSC_OSC_DIV * `RSC_CLK_KHZ / `RSC_OSC_KHZ)
`define RSC_PROC_CYC 5

`endif

// ===== common/rsc_pkg.sv
// types of the reset source controller
package rsc_pkg;

   typedef enum logic [1:0] {
      RSC_LVL_1V6 = 2'h0,
      RSC_LVL_2V5 = 2'h1,
      RSC_LVL_3V6 = 2'h2,
      RSC_LVL_4V2 = 2'h3
   } rsc_bod_lvl_t;

   typedef enum {
      ST_HOLD,
      ST_STAB,
      ST_PROC,
      ST_RUN
   } rsc_state_t;

   // one bit per reset cause, in flag order
   typedef struct packed {
      logic por;
      logic pin;
      logic wdog;
      logic dbg;
      logic brownout_detector;
   } rsc_src_t;

   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } rsc_apb_req_t;

endpackage

// ===== design/rsc_reset_ctrl.sv
// reset source controller with boot sequence and cause flags
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_defines.svh"

module rsc_reset_ctrl
   import rsc_pkg::*;
#(
   parameter int unsigned STAB_CYC = `RSC_STAB_CYC,
   parameter int unsigned CFG_CYC = `RSC_CFG_CYC,
   parameter int unsigned CNT_W = 18
) (
   // clock, reset, enable
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   // apb slave
   input wire logic [11:0] PADDR_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // reset sources
   input wire logic EXT_RESET_PIN_N_IN,
   input wire logic POR_DETECT_IN,
   input wire logic WDOG_OVERFLOW_IN,
   input wire logic WATCHDOG_ENABLE_BIT_IN,
   input wire logic DEBUG_RESET_REQ_IN,
   input wire logic BOD_TRIP_IN,
   // configuration options
   input wire logic [7:0] CFG_OPTION_IN,
   output logic [7:0] CFG_VALUE_OUT,
   output logic CFG_VALID_OUT,
   // system side
   output logic SYS_RESET_N_OUT,
   output logic [15:0] PC_START_OUT,
   output logic [1:0] BROWNOUT_LEVEL_SELECT_OUT,
   output logic BROWNOUT_ENABLE_OUT,
   output logic PIN_GPIO_MODE_OUT,
   output logic IRQ_OUT
);

   localparam int unsigned GLITCH_CYC = `RSC_GLITCH_CYC;
   localparam int unsigned GLITCH_W = 7;
   localparam int unsigned PROC_CYC = `RSC_PROC_CYC;

   function automatic logic addr_is(input logic [11:0] addr, input logic [9:0] idx);
      addr_is = (addr == {idx, 2'b00});
   endfunction

   // asynchronous inputs: {bod, por, pin}
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic pin_s;
   logic por_s;
   logic bod_s;
   logic bod_d_reg;

   // pin glitch filter
   logic [GLITCH_W-1:0] glitch_cnt_reg;
   logic [GLITCH_W-1:0] glitch_cnt_next;
   logic pin_rst_reg;
   logic pin_rst_next;

   // sequencer
   rsc_state_t state_reg;
   rsc_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic cfg_pend_reg;
   logic cfg_pend_next;
   logic [7:0] cfg_value_reg;
   logic [7:0] cfg_value_next;
   logic cfg_valid_reg;
   logic cfg_valid_next;
   logic cfg_load;
   logic stab_done;
   logic proc_done;
   logic boot_done;

   // sources
   rsc_src_t src;
   logic any_src;
   logic pin_is_reset;

   // registers
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [4:0] flag_set;
   logic [4:0] flag_wclr;
   logic [4:0] flag_pclr;
   logic [4:0] flag_next;
   logic [2:0] low_next;
   logic [`RSC_IRQ_W-1:0] istat_reg;
   logic [`RSC_IRQ_W-1:0] istat_next;
   logic [`RSC_IRQ_W-1:0] ien_reg;
   logic [`RSC_IRQ_W-1:0] ien_next;
   logic [`RSC_IRQ_W-1:0] irq_evt;
   logic [`RSC_IRQ_W-1:0] irq_wclr;
   logic irq_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [15:0] pc_start_reg;

   // apb decode
   rsc_apb_req_t req;
   logic hit_ctrl;
   logic hit_istat;
   logic hit_iclr;
   logic hit_ien;
   logic hit_cfg;
   logic hit_any;
   logic setup_rd;
   logic access;
   logic wr_en;
   logic wr_ctrl;
   logic wr_iclr;
   logic wr_ien;

   // ---------------- synchronisers and filter ----------------

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sync1_reg <= 3'h1;
         sync2_reg <= 3'h1;
      end else if (CE_IN) begin
         sync1_reg <= {BOD_TRIP_IN, POR_DETECT_IN, EXT_RESET_PIN_N_IN};
         sync2_reg <= sync1_reg;
      end
   end

   assign pin_s = sync2_reg[0];
   assign por_s = sync2_reg[1];
   assign bod_s = sync2_reg[2];

   // count continuous low time; a high sample restarts the count
   assign glitch_cnt_next = pin_s ? '0 :
      (glitch_cnt_reg == GLITCH_W'(GLITCH_CYC)) ? glitch_cnt_reg :
      glitch_cnt_reg + GLITCH_W'(1);
   assign pin_rst_next = !pin_s && (glitch_cnt_next == GLITCH_W'(GLITCH_CYC));

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         glitch_cnt_reg <= '0;
         pin_rst_reg <= 1'b0;
         bod_d_reg <= 1'b0;
      end else if (CE_IN) begin
         glitch_cnt_reg <= glitch_cnt_next;
         pin_rst_reg <= pin_rst_next;
         bod_d_reg <= bod_s;
      end
   end

   // ---------------- reset sources ----------------

   // with power-on reset alone, the pin is a port pin and is ignored here
   assign pin_is_reset = cfg_value_reg[`RSC_CFG_PINRST_BIT];
   assign PIN_GPIO_MODE_OUT = !pin_is_reset;

   assign src.por = por_s;
   assign src.pin = pin_rst_reg && pin_is_reset;
   assign src.wdog = WDOG_OVERFLOW_IN && WATCHDOG_ENABLE_BIT_IN;
   assign src.dbg = DEBUG_RESET_REQ_IN;
   // the analog comparator trips against the selected level
   assign src.brownout_detector = bod_s && ctrl_reg[`RSC_BROWNOUT_ENABLE_BIT];
   assign any_src = |src;

   // ---------------- boot sequencer ----------------

   // the interval timer restarts whenever any source is asserted
   assign stab_done = (cnt_reg == CNT_W'(STAB_CYC - 1));
   assign proc_done = (cnt_reg == CNT_W'(PROC_CYC - 1));
   assign cfg_load = (state_reg == ST_STAB) && cfg_pend_reg &&
      (cnt_reg == CNT_W'(CFG_CYC - 1));
   assign boot_done = (state_reg == ST_PROC) && proc_done && !any_src;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_HOLD: begin
            cnt_next = '0;
            if (!any_src) begin
               state_next = ST_STAB;
            end
         end
         ST_STAB: begin
            if (any_src) begin
               state_next = ST_HOLD;
               cnt_next = '0;
            end else if (stab_done) begin
               state_next = ST_PROC;
               cnt_next = '0;
            end else begin
               cnt_next = cnt_reg + CNT_W'(1);
            end
         end
         ST_PROC: begin
            if (any_src) begin
               state_next = ST_HOLD;
               cnt_next = '0;
            end else if (proc_done) begin
               state_next = ST_RUN;
               cnt_next = '0;
            end else begin
               cnt_next = cnt_reg + CNT_W'(1);
            end
         end
         default: begin
            cnt_next = '0;
            if (any_src) begin
               state_next = ST_HOLD;
            end
         end
      endcase
   end

   // options are read once per power-on, part way through the delay
   assign cfg_pend_next = src.por ? 1'b1 : (cfg_load ? 1'b0 : cfg_pend_reg);
   assign cfg_value_next = cfg_load ? CFG_OPTION_IN : cfg_value_reg;
   assign cfg_valid_next = src.por ? 1'b0 : (cfg_load ? 1'b1 : cfg_valid_reg);

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state_reg <= ST_HOLD;
         cnt_reg <= '0;
         cfg_pend_reg <= 1'b1;
         cfg_value_reg <= `RSC_CFG_RST;
         cfg_valid_reg <= 1'b0;
         pc_start_reg <= `RSC_RESET_VECTOR;
      end else if (CE_IN) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cfg_pend_reg <= cfg_pend_next;
         cfg_value_reg <= cfg_value_next;
         cfg_valid_reg <= cfg_valid_next;
         if (boot_done) begin
            pc_start_reg <= `RSC_RESET_VECTOR;
         end
      end
   end

   assign SYS_RESET_N_OUT = (state_reg == ST_RUN);
   assign PC_START_OUT = pc_start_reg;
   assign CFG_VALUE_OUT = cfg_value_reg;
   assign CFG_VALID_OUT = cfg_valid_reg;

   // ---------------- apb decode ----------------

   assign req = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
      addr: PADDR_IN, wdata: PWDATA_IN};

   assign hit_ctrl = addr_is(req.addr, `RSC_CTRL_IDX);
   assign hit_istat = addr_is(req.addr, `RSC_ISTAT_IDX);
   assign hit_iclr = addr_is(req.addr, `RSC_ICLR_IDX);
   assign hit_ien = addr_is(req.addr, `RSC_IEN_IDX);
   assign hit_cfg = addr_is(req.addr, `RSC_CFG_IDX);
   assign hit_any = hit_ctrl || hit_istat || hit_iclr || hit_ien || hit_cfg;

   // no wait states; a frozen clock stalls the bus instead
   assign PREADY_OUT = CE_IN;
   assign access = req.sel && req.enable;
   assign setup_rd = req.sel && !req.enable && !req.write;
   assign wr_en = access && req.write && CE_IN;
   assign wr_ctrl = wr_en && hit_ctrl;
   assign wr_iclr = wr_en && hit_iclr;
   assign wr_ien = wr_en && hit_ien;
   assign PSLVERR_OUT = access && !hit_any;

   // ---------------- cause flags and brown-out control ----------------

   // flags sit in bits 7..3 in the same order as the source struct
   assign flag_set = src;
   assign flag_wclr = wr_ctrl ? ~req.wdata[7:3] : 5'h00;
   // power-on wipes the other causes but never its own flag
   assign flag_pclr = {1'b0, {4{src.por}}};
   // a new cause beats a clear in the same cycle
   assign flag_next = (ctrl_reg[7:3] & ~flag_wclr & ~flag_pclr) | flag_set;

   // any system reset returns level and enable to their defaults
   assign low_next = any_src ? `RSC_CTRL_LOW_RST :
      (wr_ctrl ? req.wdata[2:0] : ctrl_reg[2:0]);
   assign ctrl_next = {flag_next, low_next};

   assign BROWNOUT_LEVEL_SELECT_OUT = ctrl_reg[`RSC_BROWNOUT_LEVEL_SELECT_MSB:`RSC_BROWNOUT_LEVEL_SELECT_LSB];
   assign BROWNOUT_ENABLE_OUT = ctrl_reg[`RSC_BROWNOUT_ENABLE_BIT];

   // ---------------- interrupts ----------------

   assign irq_evt[`RSC_IRQ_BOOT_BIT] = boot_done;
   assign irq_evt[`RSC_IRQ_BODOFF_BIT] = bod_s && !bod_d_reg && !ctrl_reg[`RSC_BROWNOUT_ENABLE_BIT];
   assign irq_evt[`RSC_IRQ_WDOFF_BIT] = WDOG_OVERFLOW_IN && !WATCHDOG_ENABLE_BIT_IN;
   assign irq_wclr = wr_iclr ? req.wdata[`RSC_IRQ_W-1:0] : '0;
   assign istat_next = (istat_reg & ~irq_wclr) | irq_evt;
   assign ien_next = wr_ien ? req.wdata[`RSC_IRQ_W-1:0] : ien_reg;

   // ---------------- read data ----------------

   always_comb begin
      rdata_next = rdata_reg;
      if (setup_rd) begin
         rdata_next = 32'h0000_0000;
         if (hit_ctrl) begin
            rdata_next[7:0] = ctrl_reg;
         end else if (hit_istat) begin
            rdata_next[`RSC_IRQ_W-1:0] = istat_reg;
         end else if (hit_ien) begin
            rdata_next[`RSC_IRQ_W-1:0] = ien_reg;
         end else if (hit_cfg) begin
            rdata_next[8:0] = {cfg_valid_reg, cfg_value_reg};
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl_reg <= `RSC_CTRL_RST;
         istat_reg <= '0;
         ien_reg <= '0;
         irq_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else if (CE_IN) begin
         ctrl_reg <= ctrl_next;
         istat_reg <= istat_next;
         ien_reg <= ien_next;
         irq_reg <= |(istat_next & ien_next);
         rdata_reg <= rdata_next;
      end
   end

   assign PRDATA_OUT = rdata_reg;
   assign IRQ_OUT = irq_reg;

endmodule

// ===== dv/rsc_reset_ctrl_asserts.sv
// port-level assertions for the reset source controller
`timescale 1ns/1ps
module rsc_reset_ctrl_asserts
   import rsc_pkg::*;
#(
   parameter int unsigned STAB_CYC = 40
) (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   // reset sources
   input wire logic EXT_RESET_PIN_N_IN,
   input wire logic POR_DETECT_IN,
   input wire logic WDOG_OVERFLOW_IN,
   input wire logic WATCHDOG_ENABLE_BIT_IN,
   input wire logic DEBUG_RESET_REQ_IN,
   input wire logic BOD_TRIP_IN,
   // observed outputs
   input wire logic SYS_RESET_N_OUT,
   input wire logic [15:0] PC_START_OUT,
   input wire logic BROWNOUT_ENABLE_OUT,
   input wire logic PIN_GPIO_MODE_OUT
);
   wire logic quiet = !POR_DETECT_IN && !DEBUG_RESET_REQ_IN
      && !(WDOG_OVERFLOW_IN && WATCHDOG_ENABLE_BIT_IN) && !(BOD_TRIP_IN && BROWNOUT_ENABLE_OUT);
   int low_cnt;
   int hi_cnt;
   // counts run on raw pins; margins absorb the two-stage sync
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         low_cnt <= 0;
         hi_cnt <= 0;
      end else begin
         low_cnt <= EXT_RESET_PIN_N_IN ? 0 : low_cnt + 1;
         hi_cnt <= (quiet && (EXT_RESET_PIN_N_IN || PIN_GPIO_MODE_OUT)) ? hi_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   dbg_reset_a: assert property (DEBUG_RESET_REQ_IN && CE_IN |=> !SYS_RESET_N_OUT)
      else $error("debug request gave no reset");
   wdog_reset_a: assert property (WDOG_OVERFLOW_IN && WATCHDOG_ENABLE_BIT_IN && CE_IN
      |=> !SYS_RESET_N_OUT) else $error("watchdog gave no reset");
   bod_reset_a: assert property ((BOD_TRIP_IN && BROWNOUT_ENABLE_OUT && CE_IN)[*3]
      |-> ##[0:1] !SYS_RESET_N_OUT) else $error("brown-out gave no reset");
   glitch_ignore_a: assert property ((quiet && low_cnt < 60)[*3] ##0 SYS_RESET_N_OUT
      |=> SYS_RESET_N_OUT) else $error("short pin low caused reset");
   pin_reset_a: assert property (low_cnt == 76 && !PIN_GPIO_MODE_OUT
      |-> !SYS_RESET_N_OUT) else $error("long pin low gave no reset");
   stab_wait_a: assert property ($rose(SYS_RESET_N_OUT) |-> hi_cnt >= STAB_CYC + 5)
      else $error("reset released too early");
   timer_release_a: assert property (hi_cnt == STAB_CYC + 12 |-> SYS_RESET_N_OUT)
      else $error("reset released too late");
   start_vector_a: assert property (PC_START_OUT == 16'h0000)
      else $error("start address not zero");
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_asserts #(.STAB_CYC(STAB_CYC)) i_rsc_reset_ctrl_asserts (
   .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
   .EXT_RESET_PIN_N_IN(EXT_RESET_PIN_N_IN), .POR_DETECT_IN(POR_DETECT_IN),
   .WDOG_OVERFLOW_IN(WDOG_OVERFLOW_IN), .WATCHDOG_ENABLE_BIT_IN(WATCHDOG_ENABLE_BIT_IN),
   .DEBUG_RESET_REQ_IN(DEBUG_RESET_REQ_IN), .BOD_TRIP_IN(BOD_TRIP_IN),
   .SYS_RESET_N_OUT(SYS_RESET_N_OUT), .PC_START_OUT(PC_START_OUT),
   .BROWNOUT_ENABLE_OUT(BROWNOUT_ENABLE_OUT), .PIN_GPIO_MODE_OUT(PIN_GPIO_MODE_OUT));

// ===== dv/rsc_src_model.sv
// external reset pin driver model
`timescale 1ns/1ps
module rsc_src_model
   import rsc_pkg::*;
(
   // command side
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic [7:0] len_in,
   // pin side, pulled up when released
   output logic pin_n_out
);
   logic [7:0] cnt_reg = 8'h00;
   always @(posedge clk_in) begin
      if (start_in) begin
         cnt_reg <= len_in;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
   assign pin_n_out = (cnt_reg == 8'h00);
endmodule

// ===== dv/rsc_reset_ctrl_tb.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ps
`include "rsc_defines.svh"
module rsc_reset_ctrl_tb
   import rsc_pkg::*;
;
   localparam int unsigned STAB = 40;
   localparam logic [11:0] A_CTRL = {`RSC_CTRL_IDX, 2'h0};
   localparam logic [11:0] A_STAT = {`RSC_ISTAT_IDX, 2'h0};
   localparam logic [11:0] A_CLR = {`RSC_ICLR_IDX, 2'h0};
   localparam logic [11:0] A_IEN = {`RSC_IEN_IDX, 2'h0};
   localparam logic [11:0] A_CFG = {`RSC_CFG_IDX, 2'h0};
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic por = 1'h0, wdog = 1'h0, wen = 1'h0, dbg = 1'h0, brownout_detector = 1'h0, go = 1'h0;
   logic [7:0] len = 8'h00;
   logic [7:0] opt = 8'h01;
   wire logic [7:0] cfg_v;
   wire logic cfg_ok;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q;
   logic e;
   int n, num_errors = 0, cmp_count = 0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, pin_n, sys_n, brownout_enable, gpio, irq;
   wire logic [15:0] pc;
   wire logic [1:0] lvl;
   rsc_reset_ctrl #(.STAB_CYC(STAB), .CFG_CYC(20)) i_rsc_reset_ctrl (
      .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'h1), .PADDR_IN(paddr), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXT_RESET_PIN_N_IN(pin_n),
      .POR_DETECT_IN(por), .WDOG_OVERFLOW_IN(wdog), .WATCHDOG_ENABLE_BIT_IN(wen),
      .DEBUG_RESET_REQ_IN(dbg), .BOD_TRIP_IN(brownout_detector), .CFG_OPTION_IN(opt),
      .CFG_VALUE_OUT(cfg_v), .CFG_VALID_OUT(cfg_ok), .SYS_RESET_N_OUT(sys_n), .PC_START_OUT(pc),
      .BROWNOUT_LEVEL_SELECT_OUT(lvl), .BROWNOUT_ENABLE_OUT(brownout_enable),
      .PIN_GPIO_MODE_OUT(gpio), .IRQ_OUT(irq));
   rsc_src_model i_rsc_src_model (.clk_in(clk), .start_in(go), .len_in(len), .pin_n_out(pin_n));
   always #50 clk = ~clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   // each transfer starts on the first edge after the task is called
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(q, x);
   endtask
   task automatic wait_up();
      n = 0;
      while (sys_n !== 1'h1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk(sys_n, 1);
   endtask
   task automatic t_boot();
      wait_up();
      chk(n >= STAB + 5 && n <= STAB + 12, 1);
      chk(pc, 32'h0);
      chk(gpio, 0);
      chk({cfg_ok, cfg_v}, 32'h101);
      rd(A_CTRL, 32'h81);
      rd(A_CFG, 32'h101);
   endtask
   task automatic t_debug();
      dbg <= 1'h1;
      @(posedge clk);
      dbg <= 1'h0;
      @(posedge clk);
      chk(sys_n, 0);
      wait_up();
      rd(A_CTRL, 32'h91);
   endtask
   task automatic t_levels();
      for (int l = 0; l < 4; l++) begin
         apb(1'h1, A_CTRL, 32'h81 | (l << 1));
         @(posedge clk);
         chk(lvl, l);
         rd(A_CTRL, 32'h81 | (l << 1));
      end
   endtask
   task automatic t_bod();
      apb(1'h1, A_CTRL, 32'h80);
      brownout_detector <= 1'h1;
      repeat (6) @(posedge clk);
      brownout_detector <= 1'h0;
      chk(sys_n, 1);
      rd(A_STAT, 32'h3);
      apb(1'h1, A_CTRL, 32'h81);
      brownout_detector <= 1'h1;
      repeat (4) @(posedge clk);
      brownout_detector <= 1'h0;
      chk(sys_n, 0);
      wait_up();
      rd(A_CTRL, 32'h89);
   endtask
   task automatic t_wdog();
      wdog <= 1'h1;
      repeat (2) @(posedge clk);
      wdog <= 1'h0;
      chk({sys_n, irq}, 2);
      apb(1'h1, A_IEN, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 1);
      apb(1'h1, A_CLR, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      wen <= 1'h1;
      wdog <= 1'h1;
      @(posedge clk);
      wen <= 1'h0;
      wdog <= 1'h0;
      @(posedge clk);
      chk(sys_n, 0);
      wait_up();
      rd(A_CTRL, 32'hA9);
   endtask
   task automatic t_pin();
      len <= 8'd40;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      repeat (60) @(posedge clk);
      chk(sys_n, 1);
      len <= 8'd100;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      repeat (100) @(posedge clk);
      chk(sys_n, 0);
      wait_up();
      chk(n >= STAB + 5 && n <= STAB + 12, 1);
      rd(A_CTRL, 32'hE9);
   endtask
   task automatic t_por();
      // power-on reloads the options; a cleared bit0 frees the pin
      opt <= 8'h00;
      por <= 1'h1;
      repeat (4) @(posedge clk);
      por <= 1'h0;
      chk(sys_n, 0);
      wait_up();
      rd(A_CTRL, 32'h81);
      chk(gpio, 1);
      rd(A_CFG, 32'h100);
      apb(1'h1, A_CTRL, 32'h01);
      rd(A_CTRL, 32'h01);
      apb(1'h0, 12'h300, 32'h0);
      chk(e, 1);
      chk(q, 0);
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      t_boot();
      t_debug();
      t_levels();
      t_bod();
      t_wdog();
      t_pin();
      t_por();
      wrap_up();
   end
endmodule
